// File: hw/sil_top.sv
// system integration: interrupt status view, reset flags, break flag protection, wait and stop
// Contract
// - interrupt status flag reads 1 while its source requests, else 0
// - bits 0,1 of status one and 7,6 of status three read zero
// - all reset sources equal priority above interrupts, no arbitration
// - break input sends the cpu to the software interrupt vector
// - during break other flags clearable only with break clear enable set
// - a flag cleared in break stays cleared afterwards
// - two-step clears stay protected in break; second step works after
// - wait or stop instruction clears the cpu interrupt mask
// - wait gates cpu clocks, peripheral clocks keep running
// - enabled interrupt wakes wait; stacking one cycle after
// - reset or break exits wait; break sets break exited wait flag
// - watchdog enabled and running in wait when disable bit is 0
// - stop resets system counter and disables both clock outputs
// - stop exits on interrupt or reset; stacking after recovery delay
// - recovery 4096 crystal cycles, or 32 with short recovery set
// - counter held from stop instruction until recovery begins
// - break status, reset status, break control at fe00, fe01, fe03
// - reading reset status clears all its flags
// - power-on sets its flag and clears others; others only set own
// - separate flags for pin, watchdog, opcode, fetch, voltage, monitor
// - break exited wait flag reads 1 only when break ended wait
// - system counter is twelve bits wide
`timescale 1ns/1ps
`default_nettype none
`include "sil_defines.svh"
module sil_top #(
  parameter int NUM_IRQ = 16,
  parameter int CNT_W = `SIL_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_IRQ:1] irq_pending,
  input wire logic irq_enabled,
  input wire logic xtal_tick,
  input wire logic por_evt,
  input wire logic pin_rst_evt,
  input wire logic wdog_rst_evt,
  input wire logic bad_opcode_evt,
  input wire logic bad_fetch_evt,
  input wire logic low_voltage_evt,
  input wire logic monitor_entry_evt,
  input wire logic break_req,
  input wire logic wait_instr,
  input wire logic stop_instr,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic bus_rate_clock_en,
  output logic crystal_clock_en,
  output logic clear_imask,
  output logic force_swi_vector,
  output logic start_stacking,
  output logic reset_req,
  output logic flag_clear_allow,
  output logic in_break,
  output logic watchdog_run,
  output logic [CNT_W-1:0] sys_count
);
  logic dp_write_q;
  logic [15:0] dp_addr_q;
  logic addr_ok;
  sil_pkg::sil_state_t state_q;
  logic brk_clr_en_q;
  logic bew_q;
  logic in_break_q;
  logic short_rec_q;
  logic wdog_dis_q;
  logic stack_q;
  logic swi_q;
  logic [7:0] rst_flags;
  logic rd_rst;
  logic any_rst;
  logic cnt_hold;
  logic cnt_done;
  logic [CNT_W-1:0] rec_target;
  logic [7:0] int_one;
  logic [7:0] int_two;
  logic [7:0] int_three;
  logic [15:0] irq_view;
  logic wake;

  // per-source pending view, straight from the request lines
  genvar gi;
  generate
    for (gi = 1; gi <= NUM_IRQ; gi++) begin : g_irq
      assign irq_view[gi-1] = irq_pending[gi];
    end
  endgenerate
  // sources 1-6 in bits 7..2, 7-14 in the second, 15-16 in bits 1..0
  assign int_one = {irq_view[0], irq_view[1], irq_view[2], irq_view[3], irq_view[4], irq_view[5], 2'b00};
  assign int_two = {irq_view[6], irq_view[7], irq_view[8], irq_view[9],
                    irq_view[10], irq_view[11], irq_view[12], irq_view[13]};
  assign int_three = {6'h00, irq_view[14], irq_view[15]};

  // bus: one-cycle address phase, zero-wait data phase, always okay
  assign addr_ok = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // capture the address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_q <= 1'b0;
      dp_addr_q <= 16'h0000;
    end else if (ce) begin
      dp_write_q <= addr_ok && hwrite;
      dp_addr_q <= haddr[15:0];
    end
  end

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && addr_ok && !hwrite) begin
      unique case (haddr[15:0])
        `SIL_ADDR_BRK_STAT: hrdata <= {30'h0, bew_q, 1'b0};
        `SIL_ADDR_RST_STAT: hrdata <= {24'h0, rst_flags};
        `SIL_ADDR_BRK_CTL: hrdata <= {31'h0, brk_clr_en_q};
        `SIL_ADDR_INT_ONE: hrdata <= {24'h0, int_one};
        `SIL_ADDR_INT_TWO: hrdata <= {24'h0, int_two};
        `SIL_ADDR_INT_THREE: hrdata <= {24'h0, int_three};
        `SIL_ADDR_CONFIG: hrdata <= {30'h0, wdog_dis_q, short_rec_q};
        `SIL_ADDR_MODE: hrdata <= {30'h0, state_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // reading the reset status clears it on the same address phase
  assign rd_rst = addr_ok && !hwrite && (haddr[15:0] == `SIL_ADDR_RST_STAT);

  // writable control bits; interrupt status addresses ignore writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_clr_en_q <= 1'b0;
      short_rec_q <= 1'b0;
      wdog_dis_q <= 1'b0;
    end else if (ce && dp_write_q) begin
      if (dp_addr_q == `SIL_ADDR_BRK_CTL) begin
        brk_clr_en_q <= hwdata[`SIL_BIT_BRK_CLR_EN];
      end
      if (dp_addr_q == `SIL_ADDR_CONFIG) begin
        short_rec_q <= hwdata[`SIL_BIT_SHORT_REC];
        wdog_dis_q <= hwdata[`SIL_BIT_WDOG_DIS];
      end
    end
  end // no write path into the interrupt status view

  assign any_rst = por_evt | pin_rst_evt | wdog_rst_evt | bad_opcode_evt | bad_fetch_evt |
                   low_voltage_evt | monitor_entry_evt;
  // any source resets at once, above interrupts, with no ordering
  assign reset_req = any_rst;

  sil_reset_flags u_rst_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .por_evt(por_evt),
    .src_evt({pin_rst_evt, wdog_rst_evt, bad_opcode_evt, bad_fetch_evt, low_voltage_evt, monitor_entry_evt}),
    .rd_clear(rd_rst),
    .flags(rst_flags)
  );

  // break state: entered on break input, left when the request drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_break_q <= 1'b0;
      swi_q <= 1'b0;
    end else if (ce) begin
      in_break_q <= break_req && !any_rst;
      swi_q <= break_req && !in_break_q && !any_rst;
    end
  end
  assign in_break = in_break_q;
  assign force_swi_vector = swi_q;
  // other modules gate their clearing on this; they keep a pending first step
  // and finish a two-step clear only once this is high again
  assign flag_clear_allow = !in_break_q || brk_clr_en_q;

  // break exited wait flag: set wins over a write of zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bew_q <= 1'b0;
    end else if (ce) begin
      if (state_q == sil_pkg::SIL_WAIT && break_req) begin
        bew_q <= 1'b1;
      end else if (dp_write_q && dp_addr_q == `SIL_ADDR_BRK_STAT && !hwdata[`SIL_BIT_BEW]) begin
        bew_q <= 1'b0;
      end
    end
  end

  assign wake = irq_enabled && (|irq_pending);
  assign rec_target = short_rec_q ? CNT_W'(`SIL_REC_SHORT) : CNT_W'(`SIL_REC_LONG);
  assign cnt_hold = (state_q == sil_pkg::SIL_STOP) || stop_instr;

  // system counter; the long count uses all twelve bits
  sil_sys_counter #(
    .W(CNT_W)
  ) u_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .xtal_tick(xtal_tick),
    .hold(cnt_hold),
    .target(rec_target),
    .count(sys_count),
    .done(cnt_done)
  );

  // low-power state machine; reset from any state returns to run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= sil_pkg::SIL_RUN;
      stack_q <= 1'b0;
    end else if (ce) begin
      stack_q <= 1'b0;
      if (any_rst) begin
        state_q <= sil_pkg::SIL_RUN;
      end else begin
        unique case (state_q)
          sil_pkg::SIL_RUN: begin
            if (stop_instr) begin
              state_q <= sil_pkg::SIL_STOP;
            end else if (wait_instr) begin
              state_q <= sil_pkg::SIL_WAIT;
            end
          end
          sil_pkg::SIL_WAIT: begin
            if (break_req) begin
              state_q <= sil_pkg::SIL_RUN;
            end else if (wake) begin
              state_q <= sil_pkg::SIL_RUN;
              stack_q <= 1'b1;
            end
          end
          sil_pkg::SIL_STOP: begin
            if (wake || break_req) begin
              state_q <= sil_pkg::SIL_RECOVER;
            end
          end
          sil_pkg::SIL_RECOVER: begin
            if (cnt_done) begin
              state_q <= sil_pkg::SIL_RUN;
              stack_q <= wake;
            end
          end
        endcase
      end
    end
  end

  assign start_stacking = stack_q;
  // both instructions open the interrupt mask so a wakeup can be taken
  assign clear_imask = (wait_instr || stop_instr) && state_q == sil_pkg::SIL_RUN;
  assign cpu_clk_en = (state_q == sil_pkg::SIL_RUN);
  assign periph_clk_en = (state_q == sil_pkg::SIL_RUN) || (state_q == sil_pkg::SIL_WAIT);
  // oscillator restarts during recovery so the counter can time it
  assign crystal_clock_en = (state_q != sil_pkg::SIL_STOP);
  assign bus_rate_clock_en = (state_q == sil_pkg::SIL_RUN) || (state_q == sil_pkg::SIL_WAIT);
  assign watchdog_run = !wdog_dis_q && periph_clk_en;
endmodule : sil_top
`default_nettype wire

// File: hw/sil_defines.svh
// register offsets, field positions and timing constants of the system integration block
`ifndef SIL_DEFINES_SVH
`define SIL_DEFINES_SVH
`define SIL_ADDR_BRK_STAT 16'hfe00
`define SIL_ADDR_RST_STAT 16'hfe01
`define SIL_ADDR_BRK_CTL 16'hfe03
`define SIL_ADDR_INT_ONE 16'hfe04
`define SIL_ADDR_INT_TWO 16'hfe05
`define SIL_ADDR_INT_THREE 16'hfe06
`define SIL_ADDR_CONFIG 16'hfe08
`define SIL_ADDR_MODE 16'hfe0c
`define SIL_BIT_BEW 1
`define SIL_BIT_BRK_CLR_EN 0
`define SIL_BIT_SHORT_REC 0
`define SIL_BIT_WDOG_DIS 1
`define SIL_RST_MONITOR 1
`define SIL_RST_LOW_VOLT 2
`define SIL_RST_BAD_FETCH 3
`define SIL_RST_BAD_OPCODE 4
`define SIL_RST_WDOG 5
`define SIL_RST_PIN 6
`define SIL_RST_POR 7
`define SIL_RST_FLAGS_POR 8'h80
`define SIL_REC_LONG 12'hfff
`define SIL_REC_SHORT 12'h01f
`define SIL_CNT_W 12
`endif

// File: hw/sil_pkg.sv
// types shared by the system integration block
`default_nettype none
package sil_pkg;
  typedef enum logic [1:0] {
    SIL_RUN = 2'b00,
    SIL_WAIT = 2'b01,
    SIL_STOP = 2'b10,
    SIL_RECOVER = 2'b11
  } sil_state_t;
endpackage : sil_pkg
`default_nettype wire

// File: hw/sil_sys_counter.sv
// twelve-bit system counter, clears while held and flags when the target is reached
`timescale 1ns/1ps
`default_nettype none
`include "sil_defines.svh"
module sil_sys_counter #(
  parameter int W = `SIL_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic xtal_tick,
  input wire logic hold,
  input wire logic [W-1:0] target,
  output logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_q;
  // counts crystal ticks; hold forces it back to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (hold) begin
        cnt_q <= '0;
      end else if (xtal_tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
  assign count = cnt_q;
  // done when the count has reached the target and a tick arrives
  assign done = !hold && xtal_tick && (cnt_q == target);
endmodule : sil_sys_counter
`default_nettype wire

// File: hw/sil_reset_flags.sv
// reset source flags: power-on clears the others, other sources accumulate, read clears
`timescale 1ns/1ps
`default_nettype none
`include "sil_defines.svh"
module sil_reset_flags (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic por_evt,
  input wire logic [5:0] src_evt,
  input wire logic rd_clear,
  output logic [7:0] flags
);
  logic [7:0] flags_q;
  logic [7:0] set_v;
  // bits 1..6 are the non power-on sources, bit 0 unused
  assign set_v = {1'b0, src_evt, 1'b0};
  // hardware sets win over the read clear; no priority among sources
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= `SIL_RST_FLAGS_POR;
    end else if (ce) begin
      if (por_evt) begin
        flags_q <= `SIL_RST_FLAGS_POR | set_v;
      end else if (rd_clear) begin
        flags_q <= set_v;
      end else begin
        flags_q <= flags_q | set_v;
      end
    end
  end
  assign flags = flags_q;
endmodule : sil_reset_flags
`default_nettype wire

// File: verification/sil_far_model.sv
// behavioural far side: crystal tick source and break module output
`timescale 1ns/1ps
`default_nettype none
module sil_far_model (
  input wire logic hclk,
  input wire logic tick_on,
  input wire logic brk,
  output logic xtal_tick,
  output logic break_req
);
  // registered so both change just after an edge, like the real sources
  always_ff @(posedge hclk) begin
    xtal_tick <= tick_on;
    break_req <= brk;
  end
endmodule : sil_far_model
`default_nettype wire

// File: verification/sil_top_chk.sv
// port-level assertions of the system integration top
`timescale 1ns/1ps
`default_nettype none
module sil_top_chk #(
  parameter int NUM_IRQ = 16,
  parameter int CNT_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [NUM_IRQ:1] irq_pending,
  input wire logic irq_enabled,
  input wire logic por_evt,
  input wire logic pin_rst_evt,
  input wire logic wdog_rst_evt,
  input wire logic bad_opcode_evt,
  input wire logic bad_fetch_evt,
  input wire logic low_voltage_evt,
  input wire logic monitor_entry_evt,
  input wire logic break_req,
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic bus_rate_clock_en,
  input wire logic crystal_clock_en,
  input wire logic clear_imask,
  input wire logic force_swi_vector,
  input wire logic start_stacking,
  input wire logic reset_req,
  input wire logic flag_clear_allow,
  input wire logic in_break,
  input wire logic [CNT_W-1:0] sys_count
);
  logic any_evt;
  logic go;
  logic waiting;
  logic wake;
  // reset events override everything, so most checks exclude them
  assign any_evt = por_evt | pin_rst_evt | wdog_rst_evt | bad_opcode_evt | bad_fetch_evt | low_voltage_evt
    | monitor_entry_evt;
  assign go = ce && !any_evt;
  assign waiting = !cpu_clk_en && periph_clk_en;
  assign wake = irq_enabled && (|irq_pending);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_RESET_REQ: assert property (any_evt |-> reset_req)
    else $error("reset event without reset request");
  AST_RESET_RUN: assert property (ce && any_evt |=> cpu_clk_en && bus_rate_clock_en)
    else $error("reset did not return to run");
  AST_IMASK: assert property (clear_imask |-> wait_instr || stop_instr)
    else $error("mask cleared without low-power instruction");
  AST_WAIT_CLK: assert property (go && clear_imask && wait_instr && !stop_instr |=> waiting)
    else $error("wait entry clock gating wrong");
  AST_STOP_CLK: assert property (go && clear_imask && stop_instr |=>
    !bus_rate_clock_en && !crystal_clock_en && sys_count == 0) else $error("stop entry wrong");
  AST_STOP_HOLD: assert property (go && clear_imask && stop_instr ##1 (go && !break_req && !wake)
    |=> sys_count == 0) else $error("counter not held in stop");
  AST_WAKE_WAIT: assert property (go && waiting && wake && !break_req |=> start_stacking)
    else $error("no stacking after wait wake");
  AST_BRK_WAIT: assert property (go && waiting && break_req |=> cpu_clk_en)
    else $error("break did not end wait");
  AST_SWI: assert property (go && $rose(break_req) |=> force_swi_vector)
    else $error("break without vector force");
  AST_FCA: assert property (!in_break |-> flag_clear_allow)
    else $error("flag clearing blocked outside break");
  // main scenarios reached
  cover property (start_stacking);
  cover property (waiting && break_req);
  cover property (!crystal_clock_en && wake);
endmodule : sil_top_chk
bind sil_top sil_top_chk #(.NUM_IRQ(NUM_IRQ), .CNT_W(CNT_W)) u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .irq_pending(irq_pending), .irq_enabled(irq_enabled), .por_evt(por_evt), .pin_rst_evt(pin_rst_evt),
  .wdog_rst_evt(wdog_rst_evt), .bad_opcode_evt(bad_opcode_evt), .bad_fetch_evt(bad_fetch_evt),
  .low_voltage_evt(low_voltage_evt), .monitor_entry_evt(monitor_entry_evt), .break_req(break_req),
  .wait_instr(wait_instr), .stop_instr(stop_instr), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
  .bus_rate_clock_en(bus_rate_clock_en), .crystal_clock_en(crystal_clock_en), .clear_imask(clear_imask),
  .force_swi_vector(force_swi_vector), .start_stacking(start_stacking), .reset_req(reset_req),
  .flag_clear_allow(flag_clear_allow), .in_break(in_break), .sys_count(sys_count));
`default_nettype wire

// File: verification/tb_system_integration_reset_lowpower.sv
// self-checking bench of the system integration top
`timescale 1ns/1ps
`default_nettype none
module tb_system_integration_reset_lowpower;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, irq_enabled = 1'b0;
  logic brk = 1'b0, tick_on = 1'b0, wait_instr = 1'b0, stop_instr = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [16:1] irq_pending = 16'h0;
  logic [7:1] ev = 7'h0;
  logic hreadyout, hresp, cpu_clk_en, periph_clk_en, bus_rate_clock_en, crystal_clock_en, clear_imask;
  logic force_swi_vector, start_stacking, reset_req, flag_clear_allow, in_break, watchdog_run, xtal_tick, break_req;
  logic [11:0] sys_count;
  int miscompares = 0, samples_checked = 0, swi_n = 0;
  sil_top #(.NUM_IRQ(16), .CNT_W(12)) dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_pending(irq_pending), .irq_enabled(irq_enabled),
    .xtal_tick(xtal_tick), .por_evt(ev[7]), .pin_rst_evt(ev[6]), .wdog_rst_evt(ev[5]), .bad_opcode_evt(ev[4]),
    .bad_fetch_evt(ev[3]), .low_voltage_evt(ev[2]), .monitor_entry_evt(ev[1]), .break_req(break_req),
    .wait_instr(wait_instr), .stop_instr(stop_instr), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .bus_rate_clock_en(bus_rate_clock_en), .crystal_clock_en(crystal_clock_en), .clear_imask(clear_imask),
    .force_swi_vector(force_swi_vector), .start_stacking(start_stacking), .reset_req(reset_req),
    .flag_clear_allow(flag_clear_allow), .in_break(in_break), .watchdog_run(watchdog_run), .sys_count(sys_count));
  sil_far_model far (.hclk(hclk), .tick_on(tick_on), .brk(brk), .xtal_tick(xtal_tick), .break_req(break_req));
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  // the vector force is a one-cycle pulse, so it is counted rather than polled
  always @(posedge hclk) begin
    if (force_swi_vector === 1'b1) swi_n++;
  end
  task end_sim;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // bounded wait for ready; hreadyout is the bus ready
  task wt_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      end_sim();
    end
  endtask : wt_rdy
  // one single-word transfer, entered just after a rising edge
  task bus(input logic w, input logic [15:0] a, input logic [7:0] wd, output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {16'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wt_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wt_rdy();
    rd = hrdata[7:0];
    chk("hresp", 0, hresp);
  endtask : bus
  task wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task rd_chk(input string nm, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(nm, {24'h0, e}, {24'h0, r});
  endtask : rd_chk
  task pulse(input logic [7:1] v);
    ev <= v;
    #1 chk("reset_req", 1, reset_req);
    @(posedge hclk);
    ev <= 7'h0;
  endtask : pulse
  task pulse_instr(input logic stp);
    wait_instr <= !stp;
    stop_instr <= stp;
    #1 chk("clear_imask", 1, clear_imask);
    @(posedge hclk);
    wait_instr <= 1'b0;
    stop_instr <= 1'b0;
  endtask : pulse_instr
  task wait_stk(input int lim, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      #1 n++;
    end while (start_stacking !== 1'b1 && n < lim);
    if (start_stacking !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    @(posedge hclk);
  endtask : wait_stk
  task t_regs;
    logic [7:0] e;
    rd_chk("rst_status", 16'hfe01, 8'h80);
    rd_chk("rst_status", 16'hfe01, 8'h00);
    for (int i = 1; i < 7; i++) begin
      e = 8'h01 << i;
      pulse(e[7:1]);
      rd_chk("rst_flag", 16'hfe01, e);
    end
    pulse(7'h20);
    pulse(7'h02);
    rd_chk("rst_accum", 16'hfe01, 8'h44);
    pulse(7'h02);
    pulse(7'h40);
    wr(16'hfe01, 8'hff);
    rd_chk("rst_por", 16'hfe01, 8'h80);
    rd_chk("unmapped", 16'hfe02, 8'h00);
    rd_chk("brk_ctl", 16'hfe03, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task t_irq;
    irq_pending <= 16'h0001;
    rd_chk("int_one", 16'hfe04, 8'h80);
    irq_pending <= 16'h8000;
    rd_chk("int_three", 16'hfe06, 8'h01);
    irq_pending <= 16'hffff;
    rd_chk("int_one", 16'hfe04, 8'hfc);
    rd_chk("int_two", 16'hfe05, 8'hff);
    rd_chk("int_three", 16'hfe06, 8'h03);
    wr(16'hfe04, 8'h00);
    rd_chk("int_one_wr", 16'hfe04, 8'hfc);
    irq_pending <= 16'h0;
    rd_chk("int_two", 16'hfe05, 8'h00);
    $display("t_irq done");
  endtask : t_irq
  task t_wait;
    int n;
    pulse_instr(1'b0);
    #1 chk("cpu_clk", 0, cpu_clk_en);
    chk("periph_clk", 1, periph_clk_en);
    chk("watchdog", 1, watchdog_run);
    @(posedge hclk);
    irq_enabled <= 1'b1;
    irq_pending <= 16'h0004;
    wait_stk(10, n);
    chk("wake_lat", 1, n);
    rd_chk("brk_wait_irq", 16'hfe00, 8'h00);
    irq_enabled <= 1'b0;
    irq_pending <= 16'h0;
    pulse_instr(1'b0);
    brk <= 1'b1;
    repeat (4) @(posedge hclk);
    #1 chk("cpu_clk", 1, cpu_clk_en);
    chk("swi", 1, swi_n);
    chk("in_break", 1, in_break);
    chk("clear_allow", 0, flag_clear_allow);
    @(posedge hclk);
    rd_chk("brk_wait", 16'hfe00, 8'h02);
    wr(16'hfe03, 8'h01);
    #1 chk("clear_allow", 1, flag_clear_allow);
    @(posedge hclk);
    wr(16'hfe03, 8'h00);
    #1 chk("clear_allow", 0, flag_clear_allow);
    @(posedge hclk);
    brk <= 1'b0;
    wr(16'hfe00, 8'h00);
    #1 chk("clear_allow", 1, flag_clear_allow);
    @(posedge hclk);
    rd_chk("brk_wait", 16'hfe00, 8'h00);
    $display("t_wait done");
  endtask : t_wait
  task t_stop(input logic [7:0] cfg, input int lo);
    int n;
    wr(16'hfe08, cfg);
    tick_on <= 1'b1;
    pulse_instr(1'b1);
    repeat (3) @(posedge hclk);
    #1 chk("crystal", 0, crystal_clock_en);
    chk("bus_rate", 0, bus_rate_clock_en);
    chk("sys_count", 0, sys_count);
    @(posedge hclk);
    irq_enabled <= 1'b1;
    irq_pending <= 16'h0100;
    wait_stk(5000, n);
    chk("recovery", lo + 1, n);
    irq_enabled <= 1'b0;
    irq_pending <= 16'h0;
    pulse_instr(1'b1);
    pulse(7'h20);
    #1 chk("reset_exit", 1, bus_rate_clock_en);
    @(posedge hclk);
    tick_on <= 1'b0;
    $display("t_stop done");
  endtask : t_stop
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_irq();
    t_wait();
    t_stop(8'h01, 32);
    t_stop(8'h00, 4096);
    end_sim();
  end
endmodule : tb_system_integration_reset_lowpower
`default_nettype wire
